// ==== hdl/drive_seq_pkg.sv ====
package drive_seq_pkg;

    // Clock rate and start-up timing.
    localparam int CLK_HZ = 40_000_000;
    localparam int SEC_PER_MIN = 60;
    localparam int RECAL_MINUTES = 30;
    localparam int RECAL_SECONDS = RECAL_MINUTES * SEC_PER_MIN;
    localparam int SPINDLE_RPM = 7_200;
    localparam longint REV_CYCLES_L = longint'(CLK_HZ) * SEC_PER_MIN / SPINDLE_RPM;

    // Counter widths.
    localparam int SEC_W = 26;
    localparam int RSEC_W = 11;
    localparam int PER_W = 20;

    // Compensation tables: one entry per radial area.
    localparam int AREAS = 14;
    localparam int IDX_W = 4;
    localparam int CUR_W = 16;
    localparam int GAIN_W = 16;
    localparam int GAIN_FRAC = 12;
    localparam logic [GAIN_W-1:0] GAIN_ONE = 16'h1000;
    localparam logic [CUR_W-1:0] FORCE_RESET = 16'h0000;

    typedef enum logic [2:0] {
        STEP_BUS_TEST, STEP_REG_TEST, STEP_RAM_TEST, STEP_BUF_TEST,
        STEP_UNLOCK, STEP_SEEK_SA, STEP_READ_SA, STEP_CAL
    } step_kind_type;

    typedef enum logic [3:0] {
        ST_BUS, ST_REG, ST_RAM, ST_SPIN, ST_BUF, ST_WAIT_SPEED, ST_UNLOCK,
        ST_SEEK_SA, ST_READ_SA, ST_CAL, ST_READY, ST_HOST, ST_FAIL
    } seq_state_type;

    typedef struct packed {
        logic req;
        step_kind_type kind;
    } step_cmd_type;

    typedef struct packed {
        logic failed;
        step_kind_type at;
    } fail_type;

    typedef struct packed {
        logic we;
        logic [IDX_W-1:0] idx;
        logic [CUR_W-1:0] force_val;
        logic [GAIN_W-1:0] gain;
    } comp_wr_type;

endpackage

// ==== hdl/drive_powerup_calibration_sequencer.sv ====
`timescale 1ns/100ps
module drive_powerup_calibration_sequencer
    import drive_seq_pkg::*;
#(
    parameter int SEC_CYCLES = CLK_HZ,
    parameter int REV_CYCLES = int'(REV_CYCLES_L)
)
(
    input wire logic clk,
    input wire logic sys_rst,
    output step_cmd_type step_cmd,
    input wire logic step_done,
    input wire logic step_ok,
    output logic spindle_on,
    output logic host_bus_en,
    output logic ready,
    output logic cal_abort,
    output logic host_cmd_go,
    output fail_type fail_status,
    input wire logic host_cmd_req,
    input wire logic host_cmd_done,
    input comp_wr_type comp_wr,
    input wire logic [IDX_W-1:0] area_idx,
    input wire logic signed [CUR_W-1:0] cmd_current,
    output logic signed [CUR_W-1:0] actuator_current,
    input wire logic spindle_at_speed_pin,
    input wire logic phase_pulse_pin,
    input wire logic servo_mark_pin,
    output logic speed_up,
    output logic speed_down,
    output logic [PER_W-1:0] last_period
);

    // Clamps a wide signed sum into the actuator current range.
    function automatic logic signed [CUR_W-1:0] sat_cur(input logic signed [CUR_W+1:0] v);
        logic signed [CUR_W+1:0] hi;
        logic signed [CUR_W+1:0] lo;
        hi = (CUR_W+2)'(2 ** (CUR_W - 1) - 1);
        lo = -(CUR_W+2)'(2 ** (CUR_W - 1));
        if (v > hi)
            sat_cur = hi[CUR_W-1:0];
        else if (v < lo)
            sat_cur = lo[CUR_W-1:0];
        else
            sat_cur = v[CUR_W-1:0];
    endfunction

    seq_state_type state_r, state_nxt;
    step_cmd_type step_r, step_nxt;
    fail_type fail_r, fail_nxt;
    logic spin_r, spin_nxt;
    logic bus_en_r, bus_en_nxt;
    logic ready_r, ready_nxt;
    logic abort_r, abort_nxt;
    logic go_r, go_nxt;
    logic cal_due_r, cal_due_nxt;
    logic [SEC_W-1:0] sec_cnt_r, sec_cnt_nxt;
    logic [RSEC_W-1:0] rsec_cnt_r, rsec_cnt_nxt;
    logic recal_tick_r, recal_tick_nxt;
    logic [2:0] sync1_r, sync2_r, prev_r;
    logic [PER_W-1:0] per_cnt_r, per_cnt_nxt;
    logic [PER_W-1:0] period_r, period_nxt;
    logic up_r, up_nxt, down_r, down_nxt;
    logic signed [CUR_W-1:0] force_tbl [AREAS];
    logic [GAIN_W-1:0] gain_tbl [AREAS];
    logic signed [CUR_W-1:0] act_r, act_nxt;
    logic at_speed;
    logic speed_edge;
    logic tbl_we;

    assign at_speed = sync2_r[0];

    // Main start-up and calibration sequence; each step is a held request.
    always_comb
    begin
        state_nxt = state_r;
        step_nxt = step_r;
        fail_nxt = fail_r;
        spin_nxt = spin_r;
        bus_en_nxt = bus_en_r;
        ready_nxt = ready_r;
        abort_nxt = 1'b0;
        go_nxt = go_r;
        cal_due_nxt = cal_due_r | recal_tick_r;
        unique case (state_r)
            ST_BUS, ST_REG, ST_RAM, ST_BUF, ST_UNLOCK, ST_SEEK_SA, ST_READ_SA, ST_CAL:
            begin
                if (!step_r.req)
                begin
                    step_nxt.req = 1'b1;
                    unique case (state_r)
                        ST_BUS: step_nxt.kind = STEP_BUS_TEST;
                        ST_REG: step_nxt.kind = STEP_REG_TEST;
                        ST_RAM: step_nxt.kind = STEP_RAM_TEST;
                        ST_BUF: step_nxt.kind = STEP_BUF_TEST;
                        ST_UNLOCK: step_nxt.kind = STEP_UNLOCK;
                        ST_SEEK_SA: step_nxt.kind = STEP_SEEK_SA;
                        ST_READ_SA: step_nxt.kind = STEP_READ_SA;
                        default: step_nxt.kind = STEP_CAL;
                    endcase
                end
                else if (state_r == ST_CAL && ready_r && host_cmd_req)
                begin
                    // Periodic calibration yields at once to a host command.
                    step_nxt.req = 1'b0;
                    abort_nxt = 1'b1;
                    go_nxt = 1'b1;
                    cal_due_nxt = 1'b1;
                    state_nxt = ST_HOST;
                end
                else if (step_done)
                begin
                    step_nxt.req = 1'b0;
                    if (!step_ok && !ready_r)
                    begin
                        fail_nxt.failed = 1'b1;
                        fail_nxt.at = step_r.kind;
                        spin_nxt = 1'b0;
                        state_nxt = ST_FAIL;
                    end
                    else
                    begin
                        unique case (state_r)
                            ST_BUS: state_nxt = ST_REG;
                            ST_REG: state_nxt = ST_RAM;
                            ST_RAM: state_nxt = ST_SPIN;
                            ST_BUF: state_nxt = ST_WAIT_SPEED;
                            ST_UNLOCK: state_nxt = ST_SEEK_SA;
                            ST_SEEK_SA: state_nxt = ST_READ_SA;
                            ST_READ_SA: state_nxt = ST_CAL;
                            default:
                            begin
                                ready_nxt = 1'b1;
                                state_nxt = ST_READY;
                            end
                        endcase
                    end
                end
            end
            ST_SPIN:
            begin
                spin_nxt = 1'b1;
                bus_en_nxt = 1'b1;
                state_nxt = ST_BUF;
            end
            ST_WAIT_SPEED:
            begin
                if (at_speed)
                    state_nxt = ST_UNLOCK;
            end
            ST_READY:
            begin
                if (host_cmd_req)
                begin
                    go_nxt = 1'b1;
                    state_nxt = ST_HOST;
                end
                else if (cal_due_r)
                begin
                    cal_due_nxt = recal_tick_r;
                    state_nxt = ST_CAL;
                end
            end
            ST_HOST:
            begin
                if (host_cmd_done)
                begin
                    go_nxt = 1'b0;
                    state_nxt = ST_READY;
                end
            end
            ST_FAIL:
            begin
                spin_nxt = 1'b0;
            end
            default:
            begin
                state_nxt = ST_FAIL;
            end
        endcase
    end

    // Registers the sequence state.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= ST_BUS;
            step_r <= '{req: 1'b0, kind: STEP_BUS_TEST};
            fail_r <= '{failed: 1'b0, at: STEP_BUS_TEST};
            spin_r <= 1'b0;
            bus_en_r <= 1'b0;
            ready_r <= 1'b0;
            abort_r <= 1'b0;
            go_r <= 1'b0;
            cal_due_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            step_r <= step_nxt;
            fail_r <= fail_nxt;
            spin_r <= spin_nxt;
            bus_en_r <= bus_en_nxt;
            ready_r <= ready_nxt;
            abort_r <= abort_nxt;
            go_r <= go_nxt;
            cal_due_r <= cal_due_nxt;
        end
    end

    // Power-on elapsed timer: a seconds prescaler and a recalibration count.
    always_comb
    begin
        sec_cnt_nxt = sec_cnt_r + 1'b1;
        rsec_cnt_nxt = rsec_cnt_r;
        recal_tick_nxt = 1'b0;
        if (sec_cnt_r == SEC_W'(SEC_CYCLES - 1))
        begin
            sec_cnt_nxt = '0;
            rsec_cnt_nxt = rsec_cnt_r + 1'b1;
            if (rsec_cnt_r == RSEC_W'(RECAL_SECONDS - 1))
            begin
                rsec_cnt_nxt = '0;
                recal_tick_nxt = 1'b1;
            end
        end
    end

    // Registers the timer; it never stops, so the schedule stays tied to power-on.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sec_cnt_r <= '0;
            rsec_cnt_r <= '0;
            recal_tick_r <= 1'b0;
        end
        else
        begin
            sec_cnt_r <= sec_cnt_nxt;
            rsec_cnt_r <= rsec_cnt_nxt;
            recal_tick_r <= recal_tick_nxt;
        end
    end

    // Tables load only while a calibration step is running.
    assign tbl_we = comp_wr.we && state_r == ST_CAL && step_r.req
        && comp_wr.idx < IDX_W'(AREAS);

    // Per-area force and gain tables, refreshed from system area data.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < AREAS; i++)
            begin
                force_tbl[i] <= FORCE_RESET;
                gain_tbl[i] <= GAIN_ONE;
            end
        end
        else if (tbl_we)
        begin
            force_tbl[comp_wr.idx] <= comp_wr.force_val;
            gain_tbl[comp_wr.idx] <= comp_wr.gain;
        end
    end

    // Scales the command by the gain ratio, then adds the balancing current.
    always_comb
    begin
        logic signed [CUR_W+GAIN_W:0] prod;
        logic signed [CUR_W+1:0] sum;
        logic [IDX_W-1:0] a;
        prod = '0;
        sum = '0;
        a = (area_idx < IDX_W'(AREAS)) ? area_idx : IDX_W'(AREAS - 1);
        prod = cmd_current * $signed({1'b0, gain_tbl[a]});
        sum = (CUR_W+2)'(prod >>> GAIN_FRAC) + (CUR_W+2)'(force_tbl[a]);
        act_nxt = sat_cur(sum);
    end

    // Two-stage synchronisers for the pin inputs.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            sync1_r <= {servo_mark_pin, phase_pulse_pin, spindle_at_speed_pin};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // Phase pulses before ready, servo marks after.
    assign speed_edge = ready_r ? (sync2_r[2] & ~prev_r[2]) : (sync2_r[1] & ~prev_r[1]);

    // Period measurement against the rated rotation period.
    always_comb
    begin
        per_cnt_nxt = (&per_cnt_r) ? per_cnt_r : per_cnt_r + 1'b1;
        period_nxt = period_r;
        up_nxt = up_r;
        down_nxt = down_r;
        if (!spin_r)
        begin
            per_cnt_nxt = '0;
            up_nxt = 1'b0;
            down_nxt = 1'b0;
        end
        else if (speed_edge)
        begin
            // Restart at one so the next capture equals the full spacing in clocks.
            per_cnt_nxt = PER_W'(1);
            period_nxt = per_cnt_r;
            up_nxt = per_cnt_r > PER_W'(REV_CYCLES);
            down_nxt = per_cnt_r < PER_W'(REV_CYCLES);
        end
    end

    // Registers speed control and the actuator current.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            per_cnt_r <= '0;
            period_r <= '0;
            up_r <= 1'b0;
            down_r <= 1'b0;
            act_r <= '0;
        end
        else
        begin
            per_cnt_r <= per_cnt_nxt;
            period_r <= period_nxt;
            up_r <= up_nxt;
            down_r <= down_nxt;
            act_r <= act_nxt;
        end
    end

    assign step_cmd = step_r;
    assign fail_status = fail_r;
    assign spindle_on = spin_r;
    assign host_bus_en = bus_en_r;
    assign ready = ready_r;
    assign cal_abort = abort_r;
    assign host_cmd_go = go_r;
    assign actuator_current = act_r;
    assign speed_up = up_r;
    assign speed_down = down_r;
    assign last_period = period_r;

    // Checks on sequence order and timing.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_test_order: assert property ($rose(step_r.req) && step_r.kind == STEP_REG_TEST
        |-> $past(state_r, 2) == ST_BUS)
        else $error("Register test did not follow bus test.");
    a_spin_after_tests: assert property ($rose(spin_r)
        |-> $past(state_r) == ST_SPIN && $past(state_r, 2) == ST_RAM)
        else $error("Spindle started before tests passed.");
    a_bus_before_buf: assert property (step_r.req && step_r.kind == STEP_BUF_TEST
        |-> host_bus_en && spin_r)
        else $error("Buffer test without host bus enabled.");
    a_unlock_at_speed: assert property ($rose(step_r.req) && step_r.kind == STEP_UNLOCK
        |-> $past(state_r, 2) == ST_WAIT_SPEED && $past(at_speed, 2))
        else $error("Heads unlocked before rated speed.");
    a_sa_before_cal: assert property ($rose(step_r.req) && step_r.kind == STEP_CAL && !ready_r
        |-> $past(state_r, 2) == ST_READ_SA)
        else $error("Calibration before system information read.");
    a_ready_after_cal: assert property ($rose(ready_r)
        |-> $past(state_r) == ST_CAL && $past(step_done) && $past(step_ok))
        else $error("Ready raised without finished calibration.");
    a_recal_due: assert property (recal_tick_r |=> cal_due_r)
        else $error("Recalibration tick lost.");
    a_cal_abort: assert property (state_r == ST_CAL && ready_r && step_r.req && host_cmd_req
        |=> abort_r && go_r && !step_r.req ##1 !abort_r && cal_due_r)
        else $error("Host command did not abort calibration.");
    a_fail_stops: assert property (fail_r.failed |-> !spin_r && !ready_r)
        else $error("Spindle running after failed test.");
    a_period_take: assert property (spin_r && speed_edge
        |=> last_period == $past(per_cnt_r))
        else $error("Measured period not captured.");

    c_ready: cover property ($rose(ready_r));
    c_abort: cover property (abort_r);
    c_fail: cover property ($rose(fail_r.failed));
    c_periodic: cover property (state_r == ST_READY ##1 state_r == ST_CAL);

endmodule

// ==== testbench/step_executor_model.sv ====
`timescale 1ns/100ps
// Stands in for the step executor: answers each step request after a fixed delay.
module step_executor_model
    import drive_seq_pkg::*;
#(
    parameter int DELAY = 30
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input step_cmd_type step_cmd,
    input wire logic fail_en,
    input step_kind_type fail_kind,
    output logic step_done,
    output logic step_ok
);
    int cnt;
    logic answered;

    // Counts while a request stands; a dropped request restarts the count, as after an abort.
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt <= 0;
            answered <= 1'b0;
            step_done <= 1'b0;
            step_ok <= 1'b0;
        end
        else
        begin
            step_done <= 1'b0;
            step_ok <= 1'b0;
            if (step_cmd.req !== 1'b1)
            begin
                cnt <= 0;
                answered <= 1'b0;
            end
            else if (!answered && cnt == DELAY)
            begin
                step_done <= 1'b1;
                step_ok <= !(fail_en && step_cmd.kind == fail_kind);
                answered <= 1'b1;
            end
            else if (!answered)
                cnt <= cnt + 1;
        end
    end
endmodule

// ==== testbench/drive_powerup_calibration_sequencer_bench.sv ====
`timescale 1ns/100ps
// Self-checking bench for the start-up and recalibration sequencer.
module drive_powerup_calibration_sequencer_bench
    import drive_seq_pkg::*;
;
    logic clk, sys_rst, step_done, step_ok, spindle_on, host_bus_en, ready, cal_abort;
    logic host_cmd_go, host_cmd_req, host_cmd_done, at_speed, phase_pin, servo_pin;
    logic speed_up, speed_down, fail_en;
    logic [PER_W-1:0] last_period;
    logic [IDX_W-1:0] area_idx;
    logic signed [CUR_W-1:0] cmd_current, actuator_current;
    step_cmd_type step_cmd;
    fail_type fail_status;
    comp_wr_type comp_wr;
    step_kind_type fail_kind;
    int mismatches, checks, cyc;

    drive_powerup_calibration_sequencer #(.SEC_CYCLES(10), .REV_CYCLES(100))
    i_drive_powerup_calibration_sequencer (.clk(clk), .sys_rst(sys_rst),
        .step_cmd(step_cmd), .step_done(step_done), .step_ok(step_ok),
        .spindle_on(spindle_on), .host_bus_en(host_bus_en), .ready(ready),
        .cal_abort(cal_abort), .host_cmd_go(host_cmd_go), .fail_status(fail_status),
        .host_cmd_req(host_cmd_req), .host_cmd_done(host_cmd_done), .comp_wr(comp_wr),
        .area_idx(area_idx), .cmd_current(cmd_current),
        .actuator_current(actuator_current), .spindle_at_speed_pin(at_speed),
        .phase_pulse_pin(phase_pin), .servo_mark_pin(servo_pin), .speed_up(speed_up),
        .speed_down(speed_down), .last_period(last_period));

    step_executor_model i_step_executor_model (.clk(clk), .sys_rst(sys_rst),
        .step_cmd(step_cmd), .fail_en(fail_en), .fail_kind(fail_kind),
        .step_done(step_done), .step_ok(step_ok));

    // Free-running 40 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Cycles since the last reset release, used to time the recalibration.
    always @(posedge clk)
        cyc <= sys_rst ? 0 : cyc + 1;

    // Cuts a hang short.
    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        final_report();
    end

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Counts one comparison and reports it at once when it fails.
    task automatic chk(input bit ok, input string msg);
        checks++;
        if (!ok)
        begin
            mismatches++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    // Holds reset for five cycles, optionally arming a failing step.
    task automatic do_reset(input logic fen, input step_kind_type fk);
        @(posedge clk);
        sys_rst <= 1'b1;
        fail_en <= fen;
        fail_kind <= fk;
        at_speed <= 1'b0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // Waits a bounded time for a step request of the given kind.
    task automatic wait_step(input step_kind_type k, input int lim);
        int n;
        n = 0;
        while (!(step_cmd.req === 1'b1 && step_cmd.kind === k) && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        chk(n < lim, "expected step request missing");
    endtask

    // Sends four pulses of the given period on the phase or servo pin.
    task automatic pulses(input bit servo, input int per);
        repeat (4)
        begin
            @(posedge clk);
            if (servo) servo_pin <= 1'b1;
            else phase_pin <= 1'b1;
            @(posedge clk);
            servo_pin <= 1'b0;
            phase_pin <= 1'b0;
            repeat (per - 2) @(posedge clk);
        end
        repeat (6) @(negedge clk);
    endtask

    // Issues one host command and ends it; in calibration it must abort and restart.
    task automatic host_cmd(input bit in_cal);
        logic abort_seen;
        int n;
        abort_seen = 1'b0;
        n = 0;
        @(posedge clk);
        host_cmd_req <= 1'b1;
        while (host_cmd_go !== 1'b1 && n < 4)
        begin
            @(negedge clk);
            abort_seen = abort_seen | (cal_abort === 1'b1);
            n++;
        end
        chk(host_cmd_go === 1'b1, "host command not granted");
        if (in_cal)
            chk(abort_seen && step_cmd.req === 1'b0, "calibration not abandoned");
        @(posedge clk);
        host_cmd_req <= 1'b0;
        host_cmd_done <= 1'b1;
        @(posedge clk);
        host_cmd_done <= 1'b0;
        if (in_cal)
            wait_step(STEP_CAL, 10);
    endtask

    // A failed initial test stops the sequence with the spindle off.
    task automatic t_fail();
        step_kind_type k;
        for (int i = 0; i < 3; i++)
        begin
            k = step_kind_type'(i);
            do_reset(1'b1, k);
            repeat (200) @(negedge clk);
            chk(fail_status.failed === 1'b1 && fail_status.at === k, "failure status");
            chk(spindle_on === 1'b0 && ready === 1'b0, "spindle ran after failure");
            chk(step_cmd.req === 1'b0, "sequence went on after failure");
        end
    endtask

    // Full start-up: order, spindle, bus, speed wait, calibration writes, ready.
    task automatic t_startup();
        do_reset(1'b0, STEP_BUS_TEST);
        wait_step(STEP_BUS_TEST, 50);
        wait_step(STEP_REG_TEST, 50);
        wait_step(STEP_RAM_TEST, 50);
        chk(spindle_on === 1'b0 && host_bus_en === 1'b0, "spindle before tests");
        wait_step(STEP_BUF_TEST, 50);
        chk(spindle_on === 1'b1 && host_bus_en === 1'b1, "bus not enabled");
        @(posedge clk);
        host_cmd_req <= 1'b1;
        pulses(1'b0, 120);
        chk(last_period === 20'h0_0078 && speed_up === 1'b1, "phase speed");
        chk(step_cmd.req === 1'b0 && host_cmd_go === 1'b0, "moved before speed");
        @(posedge clk);
        host_cmd_req <= 1'b0;
        at_speed <= 1'b1;
        wait_step(STEP_UNLOCK, 50);
        wait_step(STEP_SEEK_SA, 50);
        wait_step(STEP_READ_SA, 50);
        wait_step(STEP_CAL, 50);
        chk(ready === 1'b0, "ready during calibration");
        @(posedge clk);
        comp_wr <= '{we: 1'b1, idx: 4'h2, force_val: 16'h0010, gain: 16'h2000};
        @(posedge clk);
        comp_wr <= '{we: 1'b1, idx: 4'hE, force_val: 16'h0007, gain: 16'h3000};
        @(posedge clk);
        comp_wr <= '0;
        repeat (60) @(negedge clk);
        chk(ready === 1'b1, "not ready after calibration");
    endtask

    // Compensation on the actuator current, including an out-of-range area.
    task automatic t_comp();
        @(posedge clk);
        area_idx <= 4'h2;
        cmd_current <= 16'h0100;
        repeat (3) @(negedge clk);
        chk(actuator_current === 16'h0210, "force and gain compensation");
        @(posedge clk);
        area_idx <= 4'hE;
        repeat (3) @(negedge clk);
        chk(actuator_current === 16'h0100, "area 13 default entry");
        pulses(1'b1, 80);
        chk(last_period === 20'h0_0050 && speed_down === 1'b1, "servo speed");
    endtask

    // Periodic recalibration near 18000 cycles after power-on, aborted by a host command.
    task automatic t_recal();
        host_cmd(1'b0);
        wait_step(STEP_CAL, 20000);
        chk(cyc >= 17900 && cyc <= 18100, "recalibration interval");
        host_cmd(1'b1);
        repeat (60) @(negedge clk);
        chk(ready === 1'b1 && step_cmd.req === 1'b0, "recalibration not finished");
    endtask

    // Main sequence.
    initial
    begin
        mismatches = 0;
        checks = 0;
        sys_rst = 1'b1;
        fail_en = 1'b0;
        fail_kind = STEP_BUS_TEST;
        host_cmd_req = 1'b0;
        host_cmd_done = 1'b0;
        comp_wr = '0;
        area_idx = 4'h0;
        cmd_current = 16'h0000;
        at_speed = 1'b0;
        phase_pin = 1'b0;
        servo_pin = 1'b0;
        t_fail();
        t_startup();
        t_comp();
        t_recal();
        final_report();
    end
endmodule
